// ### logic/eeprom_consts.svh
// constants shared by the two-wire memory slave and its bus master
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH
`define EE_BYTE_W 8
`define EE_ADDR_W 13
`define EE_PAGE_W 5
`define EE_DEV_CODE 4'ha
`define EE_MASK_LARGE 13'h1fff
`define EE_MASK_SMALL 13'h0fff
`define EE_PROT_LARGE 13'h0800
`define EE_PROT_SMALL 13'h0400
`define EE_CLK_MHZ 200
`define EE_US_PER_MS 1000
`define EE_PROG_TIME_MS 10
`define EE_PWRUP_TIME_MS 1
`define EE_PROG_CYCLES (`EE_PROG_TIME_MS * `EE_US_PER_MS * `EE_CLK_MHZ)
`define EE_PWRUP_CYCLES (`EE_PWRUP_TIME_MS * `EE_US_PER_MS * `EE_CLK_MHZ)
`define MC_CMD_OFF 8'h00
`define MC_STAT_OFF 8'h04
`define MC_QTR_OFF 8'h08
`define MC_QTR_RST 8'h08
`define MC_OP_MSB 1
`define MC_NACK_BIT 2
`define MC_TXD_MSB 15
`define MC_TXD_LSB 8
`endif

// ### logic/eeprom_pkg.sv
// types shared by the two-wire memory slave and its bus master
`default_nettype none
package eeprom_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_rx = 3'b001,
      st_rack = 3'b010,
      st_tx = 3'b011,
      st_tack = 3'b100,
      st_wait = 3'b101
   } slave_state_t;
   typedef enum logic [1:0] {
      m_idle = 2'b00,
      m_start = 2'b01,
      m_stop = 2'b10,
      m_bits = 2'b11
   } master_state_t;
   typedef enum logic [1:0] {
      op_start = 2'b00,
      op_stop = 2'b01,
      op_write = 2'b10,
      op_read = 2'b11
   } bus_op_t;
endpackage
`default_nettype wire

// ### logic/two_wire_if.sv
// open-drain two-wire bus joining the master and the memory slave
`default_nettype none
interface two_wire_if;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // pull-up: a line is low only while some enabled driver pulls it low
   assign scl = ~(scl_m_oe & ~scl_m_o);
   assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
   modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
                   input scl, sda);
   modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface
`default_nettype wire

// ### logic/line_sync.sv
// two-flop synchroniser with a delayed copy for edge finding
`default_nettype none
module line_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [W-1:0] d, // asynchronous inputs
   output logic [W-1:0] q, // synchronised value
   output logic [W-1:0] q_prev // q one cycle earlier
);
   logic [W-1:0] meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= INIT;
         q <= INIT;
         q_prev <= INIT;
      end else begin
         meta_r <= d;
         q <= meta_r;
         q_prev <= q;
      end
   end
endmodule
`default_nettype wire

// ### logic/eeprom_slave.sv
// two-wire slave front end and sequencer of a byte-wide memory
`include "eeprom_consts.svh"
`default_nettype none
module eeprom_slave #(
   parameter bit LARGE_PART = 1'b1,
   parameter int PROG_CYCLES = `EE_PROG_CYCLES
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic chip_select_bit_low, // address strap, low bit
   input wire logic chip_select_bit_mid, // address strap, middle bit
   input wire logic chip_select_bit_high, // address strap, high bit
   input wire logic write_protect, // high protects bottom quarter
   output logic prog_busy, // program cycle in progress
   two_wire_if.slave bus // shared bus lines
);
   // ------------------------------------------------------------
   // sizes and sampled inputs
   // ------------------------------------------------------------
   localparam int AW = `EE_ADDR_W;
   localparam int PW = `EE_PAGE_W;
   localparam int BW = `EE_BYTE_W;
   localparam int NP = 1 << PW;
   localparam int TW = $clog2(PROG_CYCLES + 1);
   localparam int I_SCL = 5;
   localparam int I_SDA = 4;
   localparam int I_WP = 3;
   localparam logic [1:0] IDX_SLV = 2'h0;
   localparam logic [1:0] IDX_HI = 2'h1;
   localparam logic [1:0] IDX_LO = 2'h2;
   localparam logic [1:0] IDX_DATA = 2'h3;
   localparam logic [AW-1:0] AMASK =
      LARGE_PART ? `EE_MASK_LARGE : `EE_MASK_SMALL;
   localparam logic [AW-1:0] PTOP =
      LARGE_PART ? `EE_PROT_LARGE : `EE_PROT_SMALL;

   eeprom_pkg::slave_state_t state_r;
   logic [3:0] bit_cnt_r;
   logic [1:0] idx_r;
   logic [BW-1:0] sh_r;
   logic rw_r;
   logic got_ack_r;
   logic sda_oe_r;
   logic busy_r;
   logic [AW-1:0] addr_r;
   logic [TW-1:0] timer_r;
   logic [NP-1:0] vld_r;
   logic [BW-1:0] mem [0:(1<<AW)-1];
   logic [BW-1:0] page_buf [0:NP-1];
   logic [5:0] in_s;
   logic [5:0] in_q;
   logic ack_now;

   line_sync #(.W(6), .INIT(6'h3f)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({bus.scl, bus.sda, write_protect, chip_select_bit_high,
          chip_select_bit_mid, chip_select_bit_low}),
      .q(in_s),
      .q_prev(in_q)
   );

   wire logic sda_s = in_s[I_SDA];
   wire logic scl_rise = in_s[I_SCL] & ~in_q[I_SCL];
   wire logic scl_fall = ~in_s[I_SCL] & in_q[I_SCL];
   wire logic scl_held = in_s[I_SCL] & in_q[I_SCL];
   wire logic start_ev = scl_held & in_q[I_SDA] & ~in_s[I_SDA];
   wire logic stop_ev = scl_held & ~in_q[I_SDA] & in_s[I_SDA];
   // floating pins read as unknown; only a firm high counts
   wire logic wp_on = (in_s[I_WP] === 1'b1);
   wire logic [2:0] cs_val = {in_s[2] === 1'b1, in_s[1] === 1'b1,
                              in_s[0] === 1'b1};
   wire logic match = sh_r[BW-1:1] == {`EE_DEV_CODE, cs_val};
   wire logic wp_hit = wp_on && (addr_r < PTOP);
   wire logic [BW-1:0] rd_byte = mem[addr_r];

   // ------------------------------------------------------------
   // byte events
   // ------------------------------------------------------------
   wire logic byte_done = (state_r == eeprom_pkg::st_rx) && scl_fall &&
                          (bit_cnt_r == 4'(BW));
   wire logic data_ok = byte_done && ack_now && (idx_r == IDX_DATA);
   wire logic tx_load = scl_fall &&
      ((state_r == eeprom_pkg::st_rack && idx_r == IDX_SLV && rw_r) ||
       (state_r == eeprom_pkg::st_tack && got_ack_r));
   wire logic commit = busy_r && (timer_r == TW'(PROG_CYCLES - 1));

   always_comb begin
      unique case (idx_r)
         IDX_SLV: ack_now = match;
         IDX_HI: ack_now = 1'b1;
         IDX_LO: ack_now = 1'b1;
         IDX_DATA: ack_now = ~wp_hit;
      endcase
   end

   // ------------------------------------------------------------
   // bus sequencer
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= eeprom_pkg::st_idle;
         bit_cnt_r <= '0;
         idx_r <= IDX_SLV;
         sh_r <= '0;
         rw_r <= 1'b0;
         got_ack_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (start_ev) begin
         // busy: address ignored, no acknowledge
         state_r <= busy_r ? eeprom_pkg::st_wait : eeprom_pkg::st_rx;
         bit_cnt_r <= '0;
         idx_r <= IDX_SLV;
         sda_oe_r <= 1'b0;
      end else if (stop_ev) begin
         state_r <= eeprom_pkg::st_idle;
         sda_oe_r <= 1'b0;
      end else if (tx_load) begin
         state_r <= eeprom_pkg::st_tx;
         sh_r <= rd_byte;
         sda_oe_r <= ~rd_byte[BW-1];
         bit_cnt_r <= '0;
      end else begin
         unique case (state_r)
            eeprom_pkg::st_idle: ;
            eeprom_pkg::st_wait: ;
            eeprom_pkg::st_rx: begin
               if (scl_rise) begin
                  sh_r <= {sh_r[BW-2:0], sda_s};
                  bit_cnt_r <= bit_cnt_r + 1'b1;
               end else if (byte_done) begin
                  state_r <= ack_now ? eeprom_pkg::st_rack :
                                       eeprom_pkg::st_wait;
                  sda_oe_r <= ack_now;
                  if (idx_r == IDX_SLV) begin
                     rw_r <= sh_r[0];
                  end
               end
            end
            eeprom_pkg::st_rack: begin
               if (scl_fall) begin
                  state_r <= eeprom_pkg::st_rx;
                  sda_oe_r <= 1'b0;
                  bit_cnt_r <= '0;
                  if (idx_r != IDX_DATA) begin
                     idx_r <= idx_r + 1'b1;
                  end
               end
            end
            eeprom_pkg::st_tx: begin
               if (scl_fall) begin
                  if (bit_cnt_r == 4'(BW - 1)) begin
                     state_r <= eeprom_pkg::st_tack;
                     sda_oe_r <= 1'b0;
                  end else begin
                     sh_r <= {sh_r[BW-2:0], 1'b0};
                     sda_oe_r <= ~sh_r[BW-2];
                     bit_cnt_r <= bit_cnt_r + 1'b1;
                  end
               end
            end
            eeprom_pkg::st_tack: begin
               if (scl_rise) begin
                  got_ack_r <= ~sda_s;
               end else if (scl_fall) begin
                  // no acknowledge: quiet until the next start or stop
                  state_r <= eeprom_pkg::st_wait;
               end
            end
            default: state_r <= eeprom_pkg::st_idle;
         endcase
      end
   end

   // ------------------------------------------------------------
   // address counter
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r <= '0;
      end else if (byte_done && ack_now) begin
         unique case (idx_r)
            IDX_SLV: ;
            IDX_HI: addr_r <= {sh_r[AW-BW-1:0], addr_r[BW-1:0]} & AMASK;
            IDX_LO: addr_r <= {addr_r[AW-1:BW], sh_r};
            IDX_DATA: addr_r <= {addr_r[AW-1:PW], addr_r[PW-1:0] + 1'b1};
         endcase
      end else if (tx_load) begin
         addr_r <= (addr_r + 1'b1) & AMASK;
      end
   end

   // ------------------------------------------------------------
   // page buffer and array
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vld_r <= '0;
      end else if (commit || (start_ev && !busy_r)) begin
         vld_r <= '0;
      end else if (data_ok) begin
         vld_r[addr_r[PW-1:0]] <= 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (data_ok) begin
         page_buf[addr_r[PW-1:0]] <= sh_r;
      end
      if (commit) begin
         for (int i = 0; i < NP; i++) begin
            if (vld_r[i]) begin
               mem[{addr_r[AW-1:PW], PW'(i)}] <= page_buf[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // self-timed program cycle
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_r <= 1'b0;
         timer_r <= '0;
      end else if (commit) begin
         busy_r <= 1'b0;
      end else if (busy_r) begin
         timer_r <= timer_r + 1'b1;
      end else if (stop_ev && vld_r != '0) begin
         busy_r <= 1'b1;
         timer_r <= '0;
      end
   end

   assign prog_busy = busy_r;
   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe = sda_oe_r;
endmodule
`default_nettype wire

// ### logic/two_wire_master.sv
// apb-controlled two-wire bus master, one bus operation per command
`include "eeprom_consts.svh"
`default_nettype none
module two_wire_master #(
   parameter int PWRUP_CYCLES = `EE_PWRUP_CYCLES
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high writes
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   two_wire_if.master bus // shared bus lines
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   localparam int BW = `EE_BYTE_W;
   localparam int PCW = $clog2(PWRUP_CYCLES + 1);

   eeprom_pkg::master_state_t state_r;
   logic [1:0] q_r;
   logic [3:0] bit_r;
   logic [7:0] tick_r;
   logic [7:0] qtr_r;
   logic [BW:0] tx_r;
   logic [BW:0] rx_r;
   logic [BW-1:0] rx_byte_r;
   logic nack_r;
   logic ready_r;
   logic scl_r;
   logic sda_r;
   logic scl_nxt;
   logic sda_nxt;
   logic sda_s;
   logic [15:0] cmd_r;
   logic [PCW-1:0] pwr_r;

   line_sync #(.W(1), .INIT(1'b1)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(bus.sda),
      .q(sda_s),
      .q_prev()
   );

   wire logic setup = psel & ~penable;
   wire logic wr_en = psel & penable & pwrite;
   wire logic busy = state_r != eeprom_pkg::m_idle;
   wire logic launch = wr_en && (paddr == `MC_CMD_OFF) && !busy &&
                       ready_r;
   wire logic q_end = busy && (tick_r == qtr_r - 8'h01);
   wire eeprom_pkg::bus_op_t op =
      eeprom_pkg::bus_op_t'(pwdata[`MC_OP_MSB:0]);

   // ------------------------------------------------------------
   // power-up hold-off
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_r <= '0;
         ready_r <= 1'b0;
      end else if (!ready_r) begin
         pwr_r <= pwr_r + 1'b1;
         ready_r <= (pwr_r == PCW'(PWRUP_CYCLES - 1));
      end
   end

   // ------------------------------------------------------------
   // bus sequencer, four quarters per bit
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= eeprom_pkg::m_idle;
         q_r <= 2'h0;
         bit_r <= '0;
         tick_r <= '0;
         tx_r <= '0;
         rx_r <= '0;
         rx_byte_r <= '0;
         nack_r <= 1'b0;
      end else if (launch) begin
         tick_r <= '0;
         q_r <= 2'h0;
         bit_r <= '0;
         unique case (op)
            eeprom_pkg::op_start: state_r <= eeprom_pkg::m_start;
            eeprom_pkg::op_stop: state_r <= eeprom_pkg::m_stop;
            eeprom_pkg::op_write: begin
               state_r <= eeprom_pkg::m_bits;
               // ninth bit released for the slave acknowledge
               tx_r <= {pwdata[`MC_TXD_MSB:`MC_TXD_LSB], 1'b1};
            end
            eeprom_pkg::op_read: begin
               state_r <= eeprom_pkg::m_bits;
               tx_r <= {{BW{1'b1}}, pwdata[`MC_NACK_BIT]};
            end
         endcase
      end else if (busy) begin
         if (!q_end) begin
            tick_r <= tick_r + 1'b1;
         end else begin
            tick_r <= '0;
            q_r <= q_r + 1'b1;
            if (state_r == eeprom_pkg::m_bits && q_r == 2'h2) begin
               rx_r <= {rx_r[BW-1:0], sda_s};
            end
            if (q_r == 2'h3) begin
               if (state_r == eeprom_pkg::m_bits && bit_r != 4'(BW)) begin
                  bit_r <= bit_r + 1'b1;
                  tx_r <= {tx_r[BW-1:0], 1'b0};
               end else begin
                  state_r <= eeprom_pkg::m_idle;
                  if (state_r == eeprom_pkg::m_bits) begin
                     rx_byte_r <= rx_r[BW:1];
                     nack_r <= rx_r[0];
                  end
               end
            end
         end
      end
   end

   always_comb begin
      scl_nxt = scl_r;
      sda_nxt = sda_r;
      unique case (state_r)
         eeprom_pkg::m_idle: ;
         eeprom_pkg::m_start: begin
            sda_nxt = ~q_r[1];
            scl_nxt = q_r[0] ^ q_r[1];
         end
         eeprom_pkg::m_stop: begin
            sda_nxt = q_r[1];
            scl_nxt = q_r != 2'h0;
         end
         eeprom_pkg::m_bits: begin
            sda_nxt = tx_r[BW];
            scl_nxt = q_r[0] ^ q_r[1];
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_r <= 1'b1;
         sda_r <= 1'b1;
      end else begin
         scl_r <= scl_nxt;
         sda_r <= sda_nxt;
      end
   end

   // ------------------------------------------------------------
   // apb registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
         qtr_r <= `MC_QTR_RST;
         cmd_r <= '0;
      end else begin
         if (setup) begin
            prdata <= '0;
            pslverr <= 1'b0;
            if (paddr == `MC_CMD_OFF) begin
               prdata <= {16'h0000, cmd_r};
            end else if (paddr == `MC_STAT_OFF) begin
               prdata <= {16'h0000, rx_byte_r, 5'h00, ready_r, nack_r, busy};
            end else if (paddr == `MC_QTR_OFF) begin
               prdata <= {24'h000000, qtr_r};
            end else begin
               pslverr <= 1'b1;
            end
         end
         if (wr_en && paddr == `MC_QTR_OFF) begin
            qtr_r <= pwdata[7:0];
         end
         if (launch) begin
            cmd_r <= pwdata[15:0];
         end
      end
   end

   assign pready = 1'b1;
   assign bus.scl_m_o = 1'b0;
   assign bus.scl_m_oe = ~scl_r;
   assign bus.sda_m_o = 1'b0;
   assign bus.sda_m_oe = ~sda_r;
endmodule
`default_nettype wire

// ### testbench/two_wire_properties.sv
// concurrent checks on the shared two-wire bus and the memory slave
`default_nettype none
module two_wire_properties #(
   parameter int PROG_CYCLES = 1200
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic scl, // bus clock line
   input wire logic sda, // bus data line
   input wire logic sda_s_o, // slave data level
   input wire logic sda_s_oe, // slave pulls data low
   input wire logic prog_busy, // program cycle running
   input wire logic chip_select_bit_high, // strap, high bit
   input wire logic chip_select_bit_mid, // strap, middle bit
   input wire logic chip_select_bit_low // strap, low bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] bcnt_r;
   logic [8:0] sh_r;
   logic seen_r;
   int busy_r;
   int stop_r;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // -----------------------------------------------
   // bit tracking from the raw wires
   // -----------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_r <= 4'h0;
         sh_r <= 9'h000;
      end else if (scl && $fell(sda)) begin
         bcnt_r <= 4'h0;
      end else if ($rose(scl)) begin
         sh_r <= {sh_r[7:0], sda};
         if (bcnt_r != 4'hf) bcnt_r <= bcnt_r + 4'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) seen_r <= 1'b0;
      else if (scl && $fell(sda)) seen_r <= 1'b1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) busy_r <= 0;
      else busy_r <= prog_busy ? busy_r + 1 : 0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) stop_r <= 1000;
      else if (scl && $rose(sda)) stop_r <= 0;
      else if (stop_r < 1000) stop_r <= stop_r + 1;
   end
   // -----------------------------------------------
   // assertions
   // -----------------------------------------------
   sda_low_only_a: assert property (
      sda_s_oe |-> sda_s_o == 1'b0) else $error("slave drove data high");
   busy_silent_a: assert property (
      prog_busy |-> !sda_s_oe) else $error("slave pulled data while busy");
   sda_move_low_a: assert property (
      $changed(sda_s_oe) |-> !scl) else $error("slave moved data, clock high");
   busy_length_a: assert property (
      prog_busy |-> busy_r <= PROG_CYCLES + 1)
      else $error("program cycle too long");
   busy_cause_a: assert property (
      $rose(prog_busy) |-> stop_r <= 12) else $error("program without stop");
   start_first_a: assert property (
      sda_s_oe |-> seen_r) else $error("slave active before any start");
   addr_match_a: assert property (
      sda_s_oe && scl && bcnt_r == 4'd9 |-> sh_r[8:2] == {4'ha,
      chip_select_bit_high, chip_select_bit_mid, chip_select_bit_low})
      else $error("address ack without a match");
   ack_release_a: assert property (
      $fell(scl) && bcnt_r == 4'd9 && !sh_r[1] |-> ##[1:8] !sda_s_oe)
      else $error("address ack not released");
endmodule
`default_nettype wire

// ### testbench/serial_eeprom_i2c_slave_tb.sv
// testbench: bus master and memory slave joined on one two-wire bus
`default_nettype none
module serial_eeprom_i2c_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG = 1200;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, wp = 1'b0, pready, pslverr, prog_busy, e;
   logic [2:0] cs = 3'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, st, seed = 32'h4258;
   logic [7:0] mem [0:8191];
   int err_count = 0, checks = 0;
   two_wire_if bus_if();
   two_wire_master #(.PWRUP_CYCLES(20)) two_wire_master_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(bus_if));
   eeprom_slave #(.LARGE_PART(1'b1), .PROG_CYCLES(PROG)) eeprom_slave_i (
      .pclk(pclk), .presetn(presetn), .chip_select_bit_low(cs[0]),
      .chip_select_bit_mid(cs[1]), .chip_select_bit_high(cs[2]),
      .write_protect(wp), .prog_busy(prog_busy), .bus(bus_if));
   two_wire_properties #(.PROG_CYCLES(PROG)) two_wire_properties_i (
      .pclk(pclk), .presetn(presetn), .scl(bus_if.scl), .sda(bus_if.sda),
      .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe),
      .prog_busy(prog_busy), .chip_select_bit_high(cs[2]),
      .chip_select_bit_mid(cs[1]), .chip_select_bit_low(cs[0]));
   always #2.5 pclk = ~pclk;
   // -----------------------------------------------
   // helpers
   // -----------------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", w, exp, seen);
      end
   endtask
   task close_out;
      $display("counts: %0d checks, %0d mismatches", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      st = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task op(input eeprom_pkg::bus_op_t o, input logic [7:0] b,
           input logic nk);
      apb(1'b1, 8'h00, {16'h0, b, 5'h0, nk, o});
      do apb(1'b0, 8'h04, 32'h0); while (st[0] !== 1'b0);
   endtask
   task addr(input logic [12:0] a);
      op(eeprom_pkg::op_start, 8'h00, 1'b0);
      op(eeprom_pkg::op_write, {4'ha, cs, 1'b0}, 1'b0);
      chk(32'(st[1]), 32'h0, "address ack");
      op(eeprom_pkg::op_write, {3'h0, a[12:8]}, 1'b0);
      chk(32'(st[1]), 32'h0, "high address ack");
      op(eeprom_pkg::op_write, a[7:0], 1'b0);
      chk(32'(st[1]), 32'h0, "low address ack");
   endtask
   task wseq(input logic [12:0] a, input int n, input logic prot);
      logic [7:0] d;
      addr(a);
      for (int i = 0; i < n; i++) begin
         d = rnd();
         op(eeprom_pkg::op_write, d, 1'b0);
         chk(32'(st[1]), 32'(prot), "data ack");
         if (!prot) mem[a] = d;
         a = {a[12:5], a[4:0] + 5'h01};
      end
      op(eeprom_pkg::op_stop, 8'h00, 1'b0);
      op(eeprom_pkg::op_start, 8'h00, 1'b0);
      op(eeprom_pkg::op_write, {4'ha, cs, 1'b0}, 1'b0);
      chk(32'(st[1]), 32'(!prot), "first poll");
      while (st[1] !== 1'b0) begin
         op(eeprom_pkg::op_start, 8'h00, 1'b0);
         op(eeprom_pkg::op_write, {4'ha, cs, 1'b0}, 1'b0);
      end
      op(eeprom_pkg::op_stop, 8'h00, 1'b0);
   endtask
   task rseq(input logic [12:0] a, input int n, input logic sel);
      if (sel) addr(a);
      op(eeprom_pkg::op_start, 8'h00, 1'b0);
      op(eeprom_pkg::op_write, {4'ha, cs, 1'b1}, 1'b0);
      chk(32'(st[1]), 32'h0, "read address ack");
      for (int i = 0; i < n; i++) begin
         op(eeprom_pkg::op_read, 8'h00, 1'(i == n - 1));
         chk(32'(st[15:8]), 32'(mem[a]), "read data");
         a = a + 13'h0001;
      end
      op(eeprom_pkg::op_stop, 8'h00, 1'b0);
   endtask
   // -----------------------------------------------
   // tests
   // -----------------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      cs <= 3'(rnd());
      // a command before the power-up delay has run out is ignored
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(32'(st[2:0]), 32'h0, "early command");
      do apb(1'b0, 8'h04, 32'h0); while (st[2] !== 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      chk(st, 32'h8, "quarter reset");
      apb(1'b1, 8'h08, 32'h0c);
      apb(1'b0, 8'h08, 32'h0);
      chk(st, 32'hc, "quarter write");
      apb(1'b1, 8'h08, 32'h08);
      apb(1'b0, 8'h0c, 32'h0);
      chk(32'(e), 32'h1, "unmapped error");
      chk(st, 32'h0, "unmapped data");
      $display("done: registers");
      wseq(13'h0000, 1, 1'b0);
      wseq(13'h1ffe, 34, 1'b0);
      rseq(13'h1fe0, 1, 1'b0);
      rseq(13'h1ffe, 3, 1'b1);
      $display("done: write and read");
      op(eeprom_pkg::op_start, 8'h00, 1'b0);
      op(eeprom_pkg::op_write, {4'ha, ~cs, 1'b0}, 1'b0);
      chk(32'(st[1]), 32'h1, "foreign select");
      op(eeprom_pkg::op_stop, 8'h00, 1'b0);
      apb(1'b0, 8'h00, 32'h0);
      chk(st, 32'h1, "command readback");
      wp <= 1'b1;
      wseq(13'h0000, 1, 1'b1);
      wseq(13'h0800, 1, 1'b0);
      rseq(13'h0000, 1, 1'b1);
      rseq(13'h0800, 1, 1'b1);
      $display("done: protection");
      close_out;
   end
   initial begin
      repeat (60000) @(posedge pclk);
      err_count++;
      $display("unexpected end of time budget");
      close_out;
   end
endmodule
`default_nettype wire
